/* File: hdl/ddr_bank_pkg.sv */
/*
  Shared constants and types of the bank command and clock-enable tracker.
  Assumes one 50 MHz clock on which the controller's command pins are sampled.
*/
`default_nettype none
package ddr_bank_pkg;
  localparam int        NUM_BANKS    = 4;
  localparam int        CLK_PERIOD_NS = 20;
  localparam int        DLL_LOCK_CYC = 200;
  localparam int        AP_BIT       = 10;
  localparam int        ADDR_W       = 14;

  // Default timings in ns, turned into cycles below (least times round up)
  localparam int        TRCD_NS      = 15;
  localparam int        TRP_NS       = 15;
  localparam int        TWR_NS       = 15;
  localparam int        TRFC_NS      = 70;
  localparam int        TXSNR_NS     = 75;
  localparam int        TMRD_NS      = 10;
  localparam int        TRCD_CYC     = (TRCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int        TRP_CYC      = (TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int        TWR_CYC      = (TWR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int        TRFC_CYC     = (TRFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int        TXSNR_CYC    = (TXSNR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int        TMRD_CYC     = (TMRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // {ras_n, cas_n, we_n} with cs_n low
  localparam logic [2:0] CODE_NOP   = 3'h7;
  localparam logic [2:0] CODE_ACT   = 3'h3;
  localparam logic [2:0] CODE_READ  = 3'h5;
  localparam logic [2:0] CODE_WRITE = 3'h4;
  localparam logic [2:0] CODE_BST   = 3'h6;
  localparam logic [2:0] CODE_PRE   = 3'h2;
  localparam logic [2:0] CODE_REF   = 3'h1;
  localparam logic [2:0] CODE_LMR   = 3'h0;

  typedef enum logic [2:0] {
    CMD_NOP   = 3'h0,
    CMD_ACT   = 3'h1,
    CMD_READ  = 3'h2,
    CMD_WRITE = 3'h3,
    CMD_BST   = 3'h4,
    CMD_PRE   = 3'h5,
    CMD_REF   = 3'h6,
    CMD_LMR   = 3'h7
  } cmd_t;

  typedef enum logic [2:0] {
    BK_IDLE    = 3'h0,
    BK_ACTVING = 3'h1,
    BK_ACTIVE  = 3'h2,
    BK_READ    = 3'h3,
    BK_WRITE   = 3'h4,
    BK_AP_ACC  = 3'h5,
    BK_PRECHG  = 3'h6
  } bank_state_t;

  typedef enum logic [2:0] {
    PW_NORMAL   = 3'h0,
    PW_PRE_PD   = 3'h1,
    PW_ACT_PD   = 3'h2,
    PW_SELF_REF = 3'h3,
    PW_XSNR     = 3'h4,
    PW_BUSY     = 3'h5
  } power_state_t;

  // Command pins as they arrive on one edge
  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [1:0]        ba;
    logic [ADDR_W-1:0] addr;
  } cmd_pins_t;
endpackage : ddr_bank_pkg
`default_nettype wire

/* File: hdl/ddr_bank_ctrl.sv */
/*
  Bank state, concurrent auto precharge and clock-enable power state tracker.
  Assumes the command pins and clock enable arrive synchronous to clock;
  burst length and CAS latency come in as static settings.
*/
// Behaviour
// RULE_01: Deselect registers nothing, operations continue
// RULE_02: NOP accepted anywhere, operations continue
// RULE_03: Idle reference bank imposes no restriction
// RULE_04: Busy bank allows commands to other banks
// RULE_05: Controller ends read before other-bank write
// RULE_06: Controller masks write beats a read interrupts
// RULE_07: Concurrent auto precharge accepts other banks
// RULE_08: Read auto precharge starts after burst data
// RULE_09: Write auto precharge starts after write recovery
// RULE_10: Write-ap to read waits 1+BL/2 plus turnaround
// RULE_11: Read-ap to write waits rounded CL plus BL/2
// RULE_12: Same-type waits BL/2, precharge/active one
// RULE_13: Refresh and mode load need all idle
// RULE_14: Burst terminate acts on active read bank
// RULE_15: Command rules need clock enable high twice
// RULE_16: Clock enable low twice holds power state
// RULE_17: Clock enable edges enter and exit power states
// RULE_18: Clock enable stays high during column access; a fall with NOP is not flagged and enters active power down
// RULE_19: Self refresh exit waits 200 cycles before read
// RULE_20: Only deselect or NOP during exit delay
// RULE_21: Command decode from four strobes
// RULE_22: Address bit ten selects auto precharge
// RULE_23: Refresh code means self refresh when low
// RULE_24: Precharge with bit ten closes all banks
// RULE_25: One state machine per bank
// RULE_26: Uncovered combinations are flagged illegal
`default_nettype none
module ddr_bank_ctrl #(
  parameter int BURST_LEN = 4,
  parameter int CAS_LAT_X2 = 5
) (
  input  wire logic                                clock,
  input  wire logic                                srst,
  input  wire ddr_bank_pkg::cmd_pins_t             cmd_pins,
  input  wire logic                                cke,
  output logic [ddr_bank_pkg::NUM_BANKS*3-1:0]     bank_states,
  output ddr_bank_pkg::power_state_t               power_state,
  output logic                                     dll_locked,
  output logic                                     cmd_accepted,
  output logic                                     illegal_cmd
);
  localparam int NB = ddr_bank_pkg::NUM_BANKS;
  localparam int CNT_W = 8;
  localparam int HALF_BL = BURST_LEN / 2;
  localparam int cas_latency_rounded_up = (CAS_LAT_X2 + 1) / 2;
  localparam logic [CNT_W-1:0] RD_AP_CYC = CNT_W'(HALF_BL + cas_latency_rounded_up - 1);
  localparam logic [CNT_W-1:0] WR_AP_CYC = CNT_W'(HALF_BL + 1 + ddr_bank_pkg::TWR_CYC);
  localparam logic [CNT_W-1:0] RD_CYC = CNT_W'(HALF_BL);
  localparam logic [CNT_W-1:0] WR_CYC = CNT_W'(HALF_BL + 1 + ddr_bank_pkg::TWR_CYC);
  localparam logic [CNT_W-1:0] RCD_CYC = CNT_W'(ddr_bank_pkg::TRCD_CYC);
  localparam logic [CNT_W-1:0] RP_CYC = CNT_W'(ddr_bank_pkg::TRP_CYC);
  localparam logic [CNT_W-1:0] RFC_CYC = CNT_W'(ddr_bank_pkg::TRFC_CYC);
  localparam logic [CNT_W-1:0] MRD_CYC = CNT_W'(ddr_bank_pkg::TMRD_CYC);
  localparam logic [CNT_W-1:0] XSNR_CYC = CNT_W'(ddr_bank_pkg::TXSNR_CYC);
  // Exit edge is the first relock cycle but also reloads the count, so a read is first legal on the 201st edge
  localparam logic [CNT_W-1:0] DLL_CYC = CNT_W'(ddr_bank_pkg::DLL_LOCK_CYC - 1);

  // ==========================================================
  // Command decode
  function automatic ddr_bank_pkg::cmd_t decode(input ddr_bank_pkg::cmd_pins_t p);
    logic [2:0] code;
    code = {p.ras_n, p.cas_n, p.we_n};
    if (p.cs_n) begin
      return ddr_bank_pkg::CMD_NOP; // RULE_01
    end
    case (code) // RULE_21
      ddr_bank_pkg::CODE_ACT:   return ddr_bank_pkg::CMD_ACT;
      ddr_bank_pkg::CODE_READ:  return ddr_bank_pkg::CMD_READ;
      ddr_bank_pkg::CODE_WRITE: return ddr_bank_pkg::CMD_WRITE;
      ddr_bank_pkg::CODE_BST:   return ddr_bank_pkg::CMD_BST;
      ddr_bank_pkg::CODE_PRE:   return ddr_bank_pkg::CMD_PRE;
      ddr_bank_pkg::CODE_REF:   return ddr_bank_pkg::CMD_REF;
      ddr_bank_pkg::CODE_LMR:   return ddr_bank_pkg::CMD_LMR;
      default:                  return ddr_bank_pkg::CMD_NOP; // RULE_02
    endcase
  endfunction : decode

  ddr_bank_pkg::cmd_t cmd;
  logic               cke_prev_ff;
  logic               ap_bit;
  logic               cmd_window;
  logic               all_idle;
  logic               any_read;
  logic               any_col;
  logic               pw_normal;
  logic [NB-1:0]      bank_legal;
  logic [NB-1:0]      idle_vec;
  logic [NB-1:0]      read_vec;
  logic [NB-1:0]      col_vec;
  logic [1:0]         last_read_ff;
  ddr_bank_pkg::power_state_t power_ff;
  ddr_bank_pkg::power_state_t nxt_power;
  logic [CNT_W-1:0]   pw_cnt_ff;
  logic [CNT_W-1:0]   nxt_pw_cnt;
  logic [CNT_W-1:0]   dll_cnt_ff;
  logic               global_ok;

  assign cmd        = decode(cmd_pins);
  assign ap_bit     = cmd_pins.addr[ddr_bank_pkg::AP_BIT]; // RULE_22
  assign pw_normal  = (power_ff == ddr_bank_pkg::PW_NORMAL);
  assign cmd_window = cke_prev_ff && cke && pw_normal; // RULE_15
  assign all_idle   = &idle_vec;
  assign any_read   = |read_vec;
  assign any_col    = |col_vec;

  // ==========================================================
  // Per-bank state machines
  genvar b;
  generate
    for (b = 0; b < NB; b++) begin : g_bank
      ddr_bank_pkg::bank_state_t st_ff;
      ddr_bank_pkg::bank_state_t nxt_st;
      logic [CNT_W-1:0]          cnt_ff;
      logic [CNT_W-1:0]          nxt_cnt;
      logic                      ap_write_ff;
      logic                      nxt_ap_write;
      logic                      sel;
      logic                      pre_hit;
      logic                      go;

      assign sel     = (cmd_pins.ba == 2'(b));
      assign pre_hit = (cmd == ddr_bank_pkg::CMD_PRE) && (ap_bit || sel); // RULE_24
      assign go      = cmd_window && bank_legal[b];
      assign idle_vec[b] = (st_ff == ddr_bank_pkg::BK_IDLE);
      assign read_vec[b] = (st_ff == ddr_bank_pkg::BK_READ);
      assign col_vec[b]  = (st_ff == ddr_bank_pkg::BK_READ) || (st_ff == ddr_bank_pkg::BK_WRITE)
                           || (st_ff == ddr_bank_pkg::BK_AP_ACC);
      assign bank_states[b*3 +: 3] = st_ff;

      // Legality checks only this bank's own state; other banks never block it
      always_comb begin // RULE_03
        bank_legal[b] = 1'b1;
        case (cmd)
          ddr_bank_pkg::CMD_ACT:
            bank_legal[b] = !sel || st_ff == ddr_bank_pkg::BK_IDLE;
          ddr_bank_pkg::CMD_READ, ddr_bank_pkg::CMD_WRITE:
            bank_legal[b] = !sel || st_ff == ddr_bank_pkg::BK_ACTIVE
                            || st_ff == ddr_bank_pkg::BK_READ || st_ff == ddr_bank_pkg::BK_WRITE;
          ddr_bank_pkg::CMD_PRE:
            bank_legal[b] = !pre_hit || st_ff == ddr_bank_pkg::BK_IDLE
                            || st_ff == ddr_bank_pkg::BK_ACTIVE
                            || st_ff == ddr_bank_pkg::BK_READ || st_ff == ddr_bank_pkg::BK_WRITE;
          default:
            bank_legal[b] = 1'b1;
        endcase
      end

      always_comb begin // RULE_25
        nxt_st       = st_ff;
        nxt_ap_write = ap_write_ff;
        nxt_cnt      = (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
        case (st_ff)
          ddr_bank_pkg::BK_ACTVING: if (cnt_ff <= 1) nxt_st = ddr_bank_pkg::BK_ACTIVE;
          ddr_bank_pkg::BK_READ, ddr_bank_pkg::BK_WRITE:
            if (cnt_ff <= 1) nxt_st = ddr_bank_pkg::BK_ACTIVE;
          ddr_bank_pkg::BK_AP_ACC: begin
            if (cnt_ff <= 1) begin // RULE_08 RULE_09
              nxt_st  = ddr_bank_pkg::BK_PRECHG;
              nxt_cnt = RP_CYC;
            end
          end
          ddr_bank_pkg::BK_PRECHG: if (cnt_ff <= 1) nxt_st = ddr_bank_pkg::BK_IDLE;
          default: ;
        endcase
        if (go) begin // RULE_04 RULE_07
          if (cmd == ddr_bank_pkg::CMD_ACT && sel) begin
            nxt_st  = ddr_bank_pkg::BK_ACTVING;
            nxt_cnt = RCD_CYC;
          end else if ((cmd == ddr_bank_pkg::CMD_READ || cmd == ddr_bank_pkg::CMD_WRITE)
                       && sel) begin
            nxt_ap_write = (cmd == ddr_bank_pkg::CMD_WRITE);
            if (ap_bit) begin
              nxt_st  = ddr_bank_pkg::BK_AP_ACC;
              nxt_cnt = (cmd == ddr_bank_pkg::CMD_READ) ? RD_AP_CYC : WR_AP_CYC;
            end else begin
              nxt_st  = (cmd == ddr_bank_pkg::CMD_READ) ? ddr_bank_pkg::BK_READ
                                                        : ddr_bank_pkg::BK_WRITE;
              nxt_cnt = (cmd == ddr_bank_pkg::CMD_READ) ? RD_CYC : WR_CYC;
            end
          end else if (pre_hit && st_ff != ddr_bank_pkg::BK_IDLE) begin
            nxt_st  = ddr_bank_pkg::BK_PRECHG;
            nxt_cnt = RP_CYC;
          end else if (cmd == ddr_bank_pkg::CMD_BST && last_read_ff == 2'(b)
                       && st_ff == ddr_bank_pkg::BK_READ) begin // RULE_14
            nxt_st = ddr_bank_pkg::BK_ACTIVE;
          end
        end
      end

      always_ff @(posedge clock) begin
        if (srst) begin
          st_ff       <= ddr_bank_pkg::BK_IDLE;
          cnt_ff      <= '0;
          ap_write_ff <= 1'b0;
        end else begin
          st_ff       <= nxt_st;
          cnt_ff      <= nxt_cnt;
          ap_write_ff <= nxt_ap_write;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Global legality and power state
  // Refresh and mode load need every bank idle; refresh with cke low is self refresh
  assign global_ok = ((cmd == ddr_bank_pkg::CMD_REF || cmd == ddr_bank_pkg::CMD_LMR)
                      ? all_idle : 1'b1)
                     && (cmd == ddr_bank_pkg::CMD_BST ? any_read : 1'b1); // RULE_13 RULE_14

  always_comb begin // RULE_16 RULE_17
    nxt_power  = power_ff;
    nxt_pw_cnt = (pw_cnt_ff != '0) ? pw_cnt_ff - 1'b1 : pw_cnt_ff;
    case (power_ff)
      ddr_bank_pkg::PW_NORMAL: begin
        if (cke_prev_ff && !cke) begin
          if (cmd == ddr_bank_pkg::CMD_REF && all_idle) begin // RULE_23
            nxt_power = ddr_bank_pkg::PW_SELF_REF;
          end else if (cmd == ddr_bank_pkg::CMD_NOP) begin
            nxt_power = all_idle ? ddr_bank_pkg::PW_PRE_PD : ddr_bank_pkg::PW_ACT_PD;
          end
        end else if (cmd_window && global_ok && (cmd == ddr_bank_pkg::CMD_REF
                                                || cmd == ddr_bank_pkg::CMD_LMR)) begin
          nxt_power  = ddr_bank_pkg::PW_BUSY;
          nxt_pw_cnt = (cmd == ddr_bank_pkg::CMD_REF) ? RFC_CYC : MRD_CYC;
        end
      end
      ddr_bank_pkg::PW_PRE_PD, ddr_bank_pkg::PW_ACT_PD: begin
        if (!cke_prev_ff && cke && cmd == ddr_bank_pkg::CMD_NOP) begin
          nxt_power = ddr_bank_pkg::PW_NORMAL;
        end
      end
      ddr_bank_pkg::PW_SELF_REF: begin
        if (!cke_prev_ff && cke && cmd == ddr_bank_pkg::CMD_NOP) begin
          nxt_power  = ddr_bank_pkg::PW_XSNR;
          nxt_pw_cnt = XSNR_CYC;
        end
      end
      ddr_bank_pkg::PW_XSNR, ddr_bank_pkg::PW_BUSY:
        if (pw_cnt_ff <= 1) nxt_power = ddr_bank_pkg::PW_NORMAL; // RULE_15
      default: nxt_power = ddr_bank_pkg::PW_NORMAL;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cke_prev_ff  <= 1'b0;
      power_ff     <= ddr_bank_pkg::PW_NORMAL;
      pw_cnt_ff    <= '0;
      last_read_ff <= 2'h0;
    end else begin
      cke_prev_ff <= cke;
      power_ff    <= nxt_power;
      pw_cnt_ff   <= nxt_pw_cnt;
      if (cmd_window && cmd == ddr_bank_pkg::CMD_READ) last_read_ff <= cmd_pins.ba;
    end
  end

  // DLL relock count after self refresh exit
  always_ff @(posedge clock) begin // RULE_19
    if (srst) begin
      dll_cnt_ff <= '0;
    end else if (power_ff == ddr_bank_pkg::PW_SELF_REF) begin
      dll_cnt_ff <= DLL_CYC;
    end else if (dll_cnt_ff != '0) begin
      dll_cnt_ff <= dll_cnt_ff - 1'b1;
    end
  end

  // ==========================================================
  // Status outputs
  logic bad;
  assign bad = (cmd != ddr_bank_pkg::CMD_NOP) && (
                 (cmd_window && (!(&bank_legal) || !global_ok))
                 || (cmd == ddr_bank_pkg::CMD_READ && dll_cnt_ff != '0) // RULE_19
                 || (!pw_normal && cke_prev_ff)                          // RULE_20
                 || (cke_prev_ff && !cke && any_col));                   // RULE_18

  always_ff @(posedge clock) begin // RULE_26
    if (srst) begin
      illegal_cmd  <= 1'b0;
      cmd_accepted <= 1'b0;
    end else begin
      illegal_cmd  <= bad;
      // Deselect and NOP are not commands taken, so they give no pulse
      cmd_accepted <= cmd_window && !bad && (cmd != ddr_bank_pkg::CMD_NOP); // RULE_01
    end
  end

  assign power_state = power_ff;
  assign dll_locked  = (dll_cnt_ff == '0);

  // ==========================================================
  // Checks
  dll_wait_a: assert property (@(posedge clock) disable iff (srst) // RULE_19
    $fell(power_ff == ddr_bank_pkg::PW_SELF_REF) |-> !dll_locked [*8])
    else $error("dll lock reported too early");
  sr_entry_a: assert property (@(posedge clock) disable iff (srst) // RULE_17
    (pw_normal && cke_prev_ff && !cke && cmd == ddr_bank_pkg::CMD_REF && all_idle)
      |=> power_ff == ddr_bank_pkg::PW_SELF_REF)
    else $error("self refresh not entered");
  pd_hold_a: assert property (@(posedge clock) disable iff (srst) // RULE_16
    (power_ff == ddr_bank_pkg::PW_PRE_PD && !cke_prev_ff && !cke) |=> $stable(power_ff))
    else $error("power down not held");
  nop_keep_a: assert property (@(posedge clock) disable iff (srst) // RULE_01
    (cmd_pins.cs_n && g_bank[0].st_ff == ddr_bank_pkg::BK_IDLE) |=> g_bank[0].st_ff
      == ddr_bank_pkg::BK_IDLE)
    else $error("deselect changed bank state");
  pre_all_a: assert property (@(posedge clock) disable iff (srst) // RULE_24
    (cmd_window && cmd == ddr_bank_pkg::CMD_PRE && ap_bit && (&bank_legal)
     && g_bank[3].st_ff == ddr_bank_pkg::BK_ACTIVE)
      |=> g_bank[3].st_ff == ddr_bank_pkg::BK_PRECHG)
    else $error("precharge all missed a bank");
  ap_flow_a: assert property (@(posedge clock) disable iff (srst) // RULE_08
    (cmd_window && cmd == ddr_bank_pkg::CMD_READ && ap_bit && cmd_pins.ba == 2'h0
     && g_bank[0].st_ff == ddr_bank_pkg::BK_ACTIVE)
      |=> g_bank[0].st_ff == ddr_bank_pkg::BK_AP_ACC ##[1:20] g_bank[0].st_ff
        == ddr_bank_pkg::BK_PRECHG)
    else $error("auto precharge did not start");
  ref_busy_a: assert property (@(posedge clock) disable iff (srst) // RULE_13
    (cmd_window && cmd == ddr_bank_pkg::CMD_REF && !all_idle) |=> illegal_cmd)
    else $error("refresh with open bank not flagged");
  cke_rule_a: assert property (@(posedge clock) disable iff (srst) // RULE_15
    (!cke_prev_ff && cmd == ddr_bank_pkg::CMD_ACT) |=> !cmd_accepted)
    else $error("command taken with clock enable low");
endmodule : ddr_bank_ctrl
`default_nettype wire

/* File: sim/ddr_ctrl_model.sv */
/*
  Behavioural memory controller that drives the command pins and clock enable.
  Assumes the caller enters each task just after a rising clock edge.
*/
`default_nettype none
module ddr_ctrl_model (
  input  wire logic                    clock,
  output var  ddr_bank_pkg::cmd_pins_t cmd_pins,
  output var  logic                    cke
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Pin encoding, indexed by the command code
  localparam logic [2:0] CODE_OF [8] = '{ddr_bank_pkg::CODE_NOP, ddr_bank_pkg::CODE_ACT,
    ddr_bank_pkg::CODE_READ, ddr_bank_pkg::CODE_WRITE, ddr_bank_pkg::CODE_BST,
    ddr_bank_pkg::CODE_PRE, ddr_bank_pkg::CODE_REF, ddr_bank_pkg::CODE_LMR};

  initial begin
    cke      = 1'b0;
    cmd_pins = {1'b1, 19'h0};
  end

  // Deselected pins keep changing so a stale command never looks valid
  task automatic park();
    cmd_pins = {1'b1, ~cmd_pins[18:0]};
  endtask : park

  task automatic send(input ddr_bank_pkg::cmd_t c, input logic [1:0] ba,
                      input logic [13:0] addr, input logic cke_v);
    cke      = cke_v;
    cmd_pins = {1'b0, CODE_OF[c], ba, addr};
    @(posedge clock);
    #1;
    park();
  endtask : send

  task automatic idle(input int n, input logic cke_v);
    cke = cke_v;
    repeat (n) begin
      @(posedge clock);
      #1;
      park();
    end
  endtask : idle
endmodule : ddr_ctrl_model
`default_nettype wire

/* File: sim/tb.sv */
/*
  Self-checking bench of the bank and clock-enable tracker.
  Assumes the controller model is the only driver of command pins and clock enable.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [1:0] ACC = 2'h2;
  localparam logic [1:0] ILL = 2'h1;
  localparam logic [1:0] NONE = 2'h0;

  logic                                        clock;
  logic                                        srst;
  ddr_bank_pkg::cmd_pins_t                     cmd_pins;
  logic                                        cke;
  logic [ddr_bank_pkg::NUM_BANKS*3-1:0]        bank_states;
  ddr_bank_pkg::power_state_t                  power_state;
  logic                                        dll_locked;
  logic                                        cmd_accepted;
  logic                                        illegal_cmd;
  logic [1:0]                                  exp_q[$];
  logic [1:0]                                  resp_seen;
  logic [1:0]                                  resp_exp;
  int                                          error_cnt;
  int                                          total_checks;
  int                                          cyc;
  int                                          wait_n;
  int                                          b;

  ddr_ctrl_model ctl (.clock(clock), .cmd_pins(cmd_pins), .cke(cke));

  ddr_bank_ctrl #(.BURST_LEN(4), .CAS_LAT_X2(5)) dut (
    .clock(clock), .srst(srst), .cmd_pins(cmd_pins), .cke(cke),
    .bank_states(bank_states), .power_state(power_state), .dll_locked(dll_locked),
    .cmd_accepted(cmd_accepted), .illegal_cmd(illegal_cmd));

  // ==========================================================
  // Checking and closing
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic bank_is(input int bk, input ddr_bank_pkg::bank_state_t s);
    check("bank state", 16'(bank_states[3*bk +: 3]), 16'(s));
  endtask : bank_is

  task automatic pw_is(input ddr_bank_pkg::power_state_t s);
    check("power state", 16'(power_state), 16'(s));
  endtask : pw_is

  // Expected answer is queued before the command goes out
  task automatic cmd(input ddr_bank_pkg::cmd_t c, input int bk, input logic a10,
                     input logic [1:0] resp, input logic cke_v = 1'b1);
    logic [13:0] a;
    a     = 14'($urandom);
    a[10] = a10;
    if (resp !== NONE) exp_q.push_back(resp);
    ctl.send(c, 2'(bk), a, cke_v);
  endtask : cmd

  // ==========================================================
  // Clock, timeout and response monitor
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      conclude();
    end
  end

  // Sampled mid-cycle, where the one-cycle pulses are settled
  always @(negedge clock) begin
    resp_seen = {cmd_accepted, illegal_cmd};
    if (resp_seen !== NONE) begin
      resp_exp = (exp_q.size() > 0) ? exp_q.pop_front() : NONE;
      check("command response", 16'(resp_seen), 16'(resp_exp));
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    srst = 1'b1;
    void'($urandom(32'hfbe5fe4d));
    repeat (2) @(posedge clock);
    #1;
    srst = 1'b0;
    check("banks after reset", 16'(bank_states), 16'h0);
    pw_is(ddr_bank_pkg::PW_NORMAL);
    check("dll after reset", 16'(dll_locked), 16'h1);
    ctl.idle(2, 1'b1);
    // Other banks stay usable while one bursts with auto precharge
    cmd(ddr_bank_pkg::CMD_ACT, 0, 1'b0, ACC);
    cmd(ddr_bank_pkg::CMD_ACT, 1, 1'b0, ACC);
    cmd(ddr_bank_pkg::CMD_READ, 0, 1'b1, ACC);
    bank_is(0, ddr_bank_pkg::BK_AP_ACC);
    cmd(ddr_bank_pkg::CMD_NOP, 2, 1'b0, NONE);
    cmd(ddr_bank_pkg::CMD_READ, 1, 1'b0, ACC);
    bank_is(1, ddr_bank_pkg::BK_READ);
    cmd(ddr_bank_pkg::CMD_BST, 1, 1'b0, ACC);
    ctl.idle(8, 1'b1);
    bank_is(0, ddr_bank_pkg::BK_IDLE);
    bank_is(1, ddr_bank_pkg::BK_ACTIVE);
    // Refused commands leave every bank as it was
    foreach (exp_q[i]) check("queue drained", 16'h1, 16'h0);
    cmd(ddr_bank_pkg::CMD_READ, 0, 1'b0, ILL);
    cmd(ddr_bank_pkg::CMD_WRITE, 2, 1'b0, ILL);
    cmd(ddr_bank_pkg::CMD_REF, 0, 1'b0, ILL);
    ctl.idle(1, 1'b1);
    cmd(ddr_bank_pkg::CMD_LMR, 0, 1'b0, ILL);
    ctl.idle(1, 1'b1);
    pw_is(ddr_bank_pkg::PW_NORMAL);
    bank_is(0, ddr_bank_pkg::BK_IDLE);
    bank_is(1, ddr_bank_pkg::BK_ACTIVE);
    // Write with auto precharge, then a spaced read to another bank
    cmd(ddr_bank_pkg::CMD_ACT, 2, 1'b0, ACC);
    ctl.idle(1, 1'b1);
    cmd(ddr_bank_pkg::CMD_WRITE, 2, 1'b1, ACC);
    ctl.idle(2, 1'b1);
    bank_is(2, ddr_bank_pkg::BK_AP_ACC);
    ctl.idle(1, 1'b1);
    cmd(ddr_bank_pkg::CMD_READ, 1, 1'b0, ACC);
    ctl.idle(6, 1'b1);
    bank_is(2, ddr_bank_pkg::BK_IDLE);
    // Precharge all ignores the bank address
    cmd(ddr_bank_pkg::CMD_ACT, 3, 1'b0, ACC);
    ctl.idle(1, 1'b1);
    cmd(ddr_bank_pkg::CMD_PRE, $urandom % 4, 1'b1, ACC);
    ctl.idle(3, 1'b1);
    check("banks after precharge all", 16'(bank_states), 16'h0);
    // Power-down entries and exits
    cmd(ddr_bank_pkg::CMD_NOP, 0, 1'b0, NONE, 1'b0);
    pw_is(ddr_bank_pkg::PW_PRE_PD);
    cmd(ddr_bank_pkg::CMD_ACT, 0, 1'b0, NONE, 1'b0);
    ctl.idle(3, 1'b0);
    pw_is(ddr_bank_pkg::PW_PRE_PD);
    bank_is(0, ddr_bank_pkg::BK_IDLE);
    cmd(ddr_bank_pkg::CMD_NOP, 0, 1'b0, NONE, 1'b1);
    ctl.idle(2, 1'b1);
    pw_is(ddr_bank_pkg::PW_NORMAL);
    cmd(ddr_bank_pkg::CMD_ACT, 0, 1'b0, ACC);
    ctl.idle(1, 1'b1);
    cmd(ddr_bank_pkg::CMD_NOP, 0, 1'b0, NONE, 1'b0);
    pw_is(ddr_bank_pkg::PW_ACT_PD);
    ctl.idle(2, 1'b0);
    cmd(ddr_bank_pkg::CMD_NOP, 0, 1'b0, NONE, 1'b1);
    ctl.idle(2, 1'b1);
    pw_is(ddr_bank_pkg::PW_NORMAL);
    cmd(ddr_bank_pkg::CMD_PRE, 0, 1'b0, ACC);
    ctl.idle(3, 1'b1);
    // Self refresh and the relock wait on exit
    cmd(ddr_bank_pkg::CMD_REF, 0, 1'b0, NONE, 1'b0);
    pw_is(ddr_bank_pkg::PW_SELF_REF);
    ctl.idle(5, 1'b0);
    pw_is(ddr_bank_pkg::PW_SELF_REF);
    cmd(ddr_bank_pkg::CMD_NOP, 0, 1'b0, NONE, 1'b1);
    pw_is(ddr_bank_pkg::PW_XSNR);
    check("dll after exit", 16'(dll_locked), 16'h0);
    ctl.idle(ddr_bank_pkg::TXSNR_CYC + 2, 1'b1);
    pw_is(ddr_bank_pkg::PW_NORMAL);
    ctl.idle(180, 1'b1);
    check("dll still relocking", 16'(dll_locked), 16'h0);
    wait_n = ddr_bank_pkg::TXSNR_CYC + 182;
    while (dll_locked !== 1'b1 && wait_n < 230) begin
      ctl.idle(1, 1'b1);
      wait_n++;
    end
    check("dll relock delay", 16'(wait_n >= 199 && wait_n <= 202), 16'h1);
    cmd(ddr_bank_pkg::CMD_REF, 0, 1'b0, ACC);
    pw_is(ddr_bank_pkg::PW_BUSY);
    ctl.idle(ddr_bank_pkg::TRFC_CYC + 2, 1'b1);
    pw_is(ddr_bank_pkg::PW_NORMAL);
    // Random banks and rows, opened and closed singly
    repeat (6) begin
      b = $urandom % 4;
      cmd(ddr_bank_pkg::CMD_ACT, b, 1'($urandom), ACC);
      ctl.idle(1, 1'b1);
      cmd(ddr_bank_pkg::CMD_PRE, b, 1'b0, ACC);
      ctl.idle(2, 1'b1);
      bank_is(b, ddr_bank_pkg::BK_IDLE);
    end
    check("responses left over", 16'(exp_q.size()), 16'h0);
    conclude();
  end
endmodule : tb
`default_nettype wire
